//--- csm_clock_ctrl.sv
// csm_clock_ctrl.sv: clock source mode control, oscillator control and tuning registers
// assumes reset_i is raised for every reset and cold_reset_i only with power-on or brown-out
//
// Behaviour
// RULE1 - the low-gain resonator mode drives the amplifier at its lowest gain.
// RULE2 - the medium-gain resonator mode selects the intermediate amplifier gain.
// RULE3 - the high-gain resonator mode selects the highest amplifier gain.
// RULE4 - rc mode with clock out takes the rc clock on the input pin and drives the output pin at a quarter of it.
// RULE5 - rc mode with io frees the output pin as a general purpose pin.
// RULE6 - every reset loads the frequency select with 10 and the two status bits follow the oscillator.
// RULE7 - the six-bit tuning value clears only on power-on or brown-out and its upper bits read zero.
// RULE8 - the configuration words sit at program addresses 2007h and 2008h.
// RULE9 - configuration words are reached only through the programming port, never by software.
// RULE10 - word one holds oscillator select, watchdog, power-up timer, reset pin, protect, brown-out, multiplier and debug bits, erased ones reading 1.
// RULE11 - the system clock source follows the oscillator select of word one.
// RULE12 - resonator modes hold the device in reset until 1024 oscillations after power-on or wake-up.
// RULE13 - frequency select 10 means 8 MHz with the multiplier on and 250 kHz with it off.
// RULE14 - reserved bits of the configuration word do not affect the mode decode.
`timescale 1ns/100ps
`include "csm_clock_map.svh"
module csm_clock_ctrl (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic cold_reset_i,
   input wire logic wake_i,
   // software register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // programming port
   input wire logic prog_mode_i,
   input wire logic [13:0] prog_addr_i,
   input wire logic [15:0] prog_wdata_i,
   input wire logic prog_wr_i,
   input wire logic prog_rd_i,
   output logic [15:0] prog_rdata_o,
   // internal oscillator
   input wire logic osc_locked_i,
   input wire logic osc_stable_i,
   input wire logic intosc_clk_i,
   output logic [1:0] postscale_sel_o,
   output logic freq_multiplier_on_o,
   output logic [5:0] tuning_value_o,
   // oscillator pins
   input wire logic osc_pin_in_i,
   input wire logic osc_pin_out_i,
   output logic osc_pin_out_o,
   output logic osc_pin_out_oe_n_o,
   input wire logic gpio_out_i,
   input wire logic gpio_oe_n_i,
   output logic gpio_in_o,
   output logic osc_pin_in_gpio_o,
   // clocking and start-up
   output logic [1:0] amp_gain_o,
   output logic use_external_o,
   output logic external_from_pin_o,
   output logic device_hold_reset_o,
   output logic watchdog_on_o,
   output logic powerup_timer_on_o,
   output logic reset_pin_function_on_o,
   output logic code_protect_bit_o,
   output logic [1:0] brownout_reset_select_o,
   output logic brownout_level_select_o,
   output logic debug_on_o
);
   logic [15:0] cfg1;
   logic [2:0] osc_sel;
   csm_pkg::csm_mode_e mode;
   csm_pkg::csm_gain_e gain_d;
   csm_pkg::csm_gain_e gain_q;
   csm_pkg::csm_ost_e ost_q;
   logic [10:0] ost_cnt_q;
   logic [1:0] freq_sel_q;
   logic [5:0] tune_q;
   logic [7:0] rdata_q;
   logic [7:0] ctrl_view;
   logic [7:0] status_view;
   logic osc_in_q;
   logic osc_rise;
   logic divided_clock_output_en;
   logic divided_clock_output_src;
   logic divided_clock_output;
   logic resonator;
   logic ost_start_q;
   logic pin_drv_q;
   logic pin_oe_n_q;
   logic tune_reset;

   // words change only in a programming session or on a cold reset, so the decode never runs on a half-written word
   csm_config_store csm_config_store_i (
      .clock_i(clock_i),
      .cold_reset_i(cold_reset_i),
      .prog_mode_i(prog_mode_i),
      .prog_addr_i(prog_addr_i),
      .prog_wdata_i(prog_wdata_i),
      .prog_wr_i(prog_wr_i),
      .prog_rd_i(prog_rd_i),
      .prog_rdata_o(prog_rdata_o),
      .cfg1_o(cfg1)
   );

   // only the three select bits reach the decode
   assign osc_sel = cfg1[`CSM_CFG_OSC_HI:`CSM_CFG_OSC_LO]; // RULE14

   always_comb begin
      unique case (osc_sel) // RULE11
         `CSM_OSC_LP: mode = csm_pkg::CSM_MODE_LOW_GAIN;
         `CSM_OSC_XT: mode = csm_pkg::CSM_MODE_MED_GAIN;
         `CSM_OSC_HS: mode = csm_pkg::CSM_MODE_HIGH_GAIN;
         `CSM_OSC_EC: mode = csm_pkg::CSM_MODE_EXT_CLOCK;
         `CSM_OSC_INTIO: mode = csm_pkg::CSM_MODE_INT_IO;
         `CSM_OSC_INTCLK: mode = csm_pkg::CSM_MODE_INT_DIVIDED_CLOCK_OUTPUT;
         `CSM_OSC_RC_OSC_WITH_IO_PIN: mode = csm_pkg::CSM_MODE_RC_IO;
         `CSM_OSC_RC: mode = csm_pkg::CSM_MODE_RC_DIVIDED_CLOCK_OUTPUT;
      endcase
   end

   always_comb begin
      unique case (mode)
         csm_pkg::CSM_MODE_LOW_GAIN: gain_d = csm_pkg::CSM_GAIN_LOW; // RULE1
         csm_pkg::CSM_MODE_MED_GAIN: gain_d = csm_pkg::CSM_GAIN_MED; // RULE2
         csm_pkg::CSM_MODE_HIGH_GAIN: gain_d = csm_pkg::CSM_GAIN_HIGH; // RULE3
         default: gain_d = csm_pkg::CSM_GAIN_OFF;
      endcase
   end

   assign resonator = (mode == csm_pkg::CSM_MODE_LOW_GAIN) ||
                      (mode == csm_pkg::CSM_MODE_MED_GAIN) ||
                      (mode == csm_pkg::CSM_MODE_HIGH_GAIN);

   // gain registered so the analog amplifier never sees decode glitches
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         gain_q <= csm_pkg::CSM_GAIN_OFF;
      end else begin
         gain_q <= gain_d; // RULE1 RULE2 RULE3
      end
   end

   assign amp_gain_o = gain_q;

   // clock source selection
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         use_external_o <= 1'b0;
         external_from_pin_o <= 1'b0;
         osc_pin_in_gpio_o <= 1'b0;
      end else begin
         use_external_o <= (mode != csm_pkg::CSM_MODE_INT_IO) &&
                           (mode != csm_pkg::CSM_MODE_INT_DIVIDED_CLOCK_OUTPUT); // RULE11
         external_from_pin_o <= !resonator &&
                                (mode != csm_pkg::CSM_MODE_INT_IO) &&
                                (mode != csm_pkg::CSM_MODE_INT_DIVIDED_CLOCK_OUTPUT);
         osc_pin_in_gpio_o <= (mode == csm_pkg::CSM_MODE_INT_IO) ||
                              (mode == csm_pkg::CSM_MODE_INT_DIVIDED_CLOCK_OUTPUT);
      end
   end

   // configuration option outputs
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         watchdog_on_o <= 1'b0;
         powerup_timer_on_o <= 1'b0;
         reset_pin_function_on_o <= 1'b0;
         code_protect_bit_o <= 1'b0;
         brownout_reset_select_o <= 2'h0;
         brownout_level_select_o <= 1'b0;
         debug_on_o <= 1'b0;
         freq_multiplier_on_o <= 1'b0;
      end else begin
         watchdog_on_o <= cfg1[`CSM_CFG_WDT_BIT]; // RULE10
         powerup_timer_on_o <= cfg1[`CSM_CFG_PWRT_BIT];
         reset_pin_function_on_o <= cfg1[`CSM_CFG_RSTPIN_BIT];
         code_protect_bit_o <= cfg1[`CSM_CFG_CP_BIT];
         brownout_reset_select_o <= cfg1[`CSM_CFG_BORSEL_HI:`CSM_CFG_BORSEL_LO];
         brownout_level_select_o <= cfg1[`CSM_CFG_BORLVL_BIT];
         debug_on_o <= cfg1[`CSM_CFG_DEBUG_BIT];
         freq_multiplier_on_o <= cfg1[`CSM_CFG_MULT_BIT]; // RULE13
      end
   end

   // divided clock output from the rc or internal clock
   assign divided_clock_output_en = (mode == csm_pkg::CSM_MODE_RC_DIVIDED_CLOCK_OUTPUT) ||
                      (mode == csm_pkg::CSM_MODE_INT_DIVIDED_CLOCK_OUTPUT);
   assign divided_clock_output_src = (mode == csm_pkg::CSM_MODE_RC_DIVIDED_CLOCK_OUTPUT) ? osc_pin_in_i : intosc_clk_i; // RULE4

   // the divider sees the pin level, so the rc clock must stay well below clock_i
   csm_divided_clock_output_div csm_divided_clock_output_div_i (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .enable_i(divided_clock_output_en),
      .src_i(divided_clock_output_src),
      .div_o(divided_clock_output)
   );

   // output pin: divided clock, freed gpio, or left to the resonator
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         pin_drv_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
      end else if (divided_clock_output_en) begin
         pin_drv_q <= divided_clock_output; // RULE4
         pin_oe_n_q <= 1'b0;
      end else if ((mode == csm_pkg::CSM_MODE_RC_IO) ||
                   (mode == csm_pkg::CSM_MODE_EXT_CLOCK) ||
                   (mode == csm_pkg::CSM_MODE_INT_IO)) begin
         pin_drv_q <= gpio_out_i; // RULE5
         pin_oe_n_q <= gpio_oe_n_i;
      end else begin
         pin_drv_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
      end
   end

   assign osc_pin_out_o = pin_drv_q;
   assign osc_pin_out_oe_n_o = pin_oe_n_q;

   // the pin reads back as gpio input whatever drives it
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         gpio_in_o <= 1'b0;
      end else begin
         gpio_in_o <= osc_pin_out_i; // RULE5
      end
   end

   // resonator start-up: count oscillations on the input pin
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         osc_in_q <= 1'b0;
         ost_start_q <= 1'b1;
      end else begin
         osc_in_q <= osc_pin_in_i;
         ost_start_q <= wake_i;
      end
   end

   assign osc_rise = osc_pin_in_i && !osc_in_q;

   // a start follows reset release or a wake pulse; a wake restarts the count only once start-up is done, and is ignored while counting
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ost_q <= csm_pkg::CSM_OST_IDLE;
         ost_cnt_q <= 11'h000;
      end else begin
         unique case (ost_q)
            csm_pkg::CSM_OST_IDLE: begin
               ost_cnt_q <= 11'h000;
               if (ost_start_q && resonator) begin
                  ost_q <= csm_pkg::CSM_OST_COUNT; // RULE12
               end else if (ost_start_q) begin
                  ost_q <= csm_pkg::CSM_OST_DONE;
               end
            end
            csm_pkg::CSM_OST_COUNT: begin
               if (!resonator) begin
                  ost_q <= csm_pkg::CSM_OST_DONE;
               end else if (osc_rise) begin
                  ost_cnt_q <= ost_cnt_q + 11'h001;
                  if (ost_cnt_q == `CSM_OST_COUNT - 11'h001) begin
                     ost_q <= csm_pkg::CSM_OST_DONE; // RULE12
                  end
               end
            end
            csm_pkg::CSM_OST_DONE: begin
               if (wake_i) begin
                  ost_q <= csm_pkg::CSM_OST_IDLE;
               end
            end
            default: ost_q <= csm_pkg::CSM_OST_IDLE;
         endcase
      end
   end

   assign device_hold_reset_o = (ost_q != csm_pkg::CSM_OST_DONE); // RULE12

   // frequency select: every reset returns it to the default
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         freq_sel_q <= `CSM_FREQ_SEL_RESET; // RULE6
      end else if (reg_wr_i && reg_addr_i == `CSM_OFS_OSC_CONTROL) begin
         freq_sel_q <= reg_wdata_i[`CSM_FREQ_SEL_HI:`CSM_FREQ_SEL_LO];
      end
   end

   // 10 maps to divide by two of either base: 8 MHz or 250 kHz
   assign postscale_sel_o = 2'h3 - freq_sel_q; // RULE13

   // tuning keeps its value across warm resets, so only the cold reset clears it
   assign tune_reset = cold_reset_i;

   always_ff @(posedge clock_i or posedge tune_reset) begin
      if (tune_reset) begin
         tune_q <= `CSM_TUNE_RESET; // RULE7
      end else if (!reset_i && reg_wr_i && reg_addr_i == `CSM_OFS_OSC_TUNING) begin
         tune_q <= reg_wdata_i[`CSM_TUNE_HI:0];
      end
   end

   assign tuning_value_o = tune_q;

   // read views; unimplemented bits read zero
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[`CSM_FREQ_SEL_HI:`CSM_FREQ_SEL_LO] = freq_sel_q;
      ctrl_view[`CSM_LOCKED_BIT] = osc_locked_i; // RULE6
      ctrl_view[`CSM_STABLE_BIT] = osc_stable_i; // RULE6
   end

   assign status_view = {device_hold_reset_o, 2'h0, gain_q, osc_sel};

   // registers are read one cycle after the strobe; config words never appear here
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            `CSM_OFS_OSC_CONTROL: rdata_q <= ctrl_view;
            `CSM_OFS_OSC_TUNING: rdata_q <= {2'h0, tune_q}; // RULE7
            `CSM_OFS_MODE_STATUS: rdata_q <= status_view;
            default: rdata_q <= 8'h00; // RULE9
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata_o = rdata_q;
endmodule // csm_clock_ctrl

//--- csm_clock_ctrl_props.sv
// csm_clock_ctrl_props.sv: port assertions of the clock mode block
// assumes a bind onto csm_clock_ctrl, one clock domain, reset_i async high
`timescale 1ns/100ps
module csm_clock_ctrl_props (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic wake_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic prog_mode_i,
   input wire logic [13:0] prog_addr_i,
   input wire logic prog_rd_i,
   input wire logic [15:0] prog_rdata_o,
   input wire logic [1:0] postscale_sel_o,
   input wire logic [5:0] tuning_value_o,
   input wire logic osc_pin_in_gpio_o,
   input wire logic [1:0] amp_gain_o,
   input wire logic use_external_o,
   input wire logic external_from_pin_o,
   input wire logic device_hold_reset_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   a_read_data_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data not idle");
   a_freq_sel_read: assert property (reg_rd_i && reg_addr_i == 8'h00 |=>
      reg_rdata_o[7:4] == {2'h0, 2'h3 - $past(postscale_sel_o)} && reg_rdata_o[1:0] == 2'h0)
      else $error("control read wrong");
   a_tuning_read: assert property (reg_rd_i && reg_addr_i == 8'h01 |=>
      reg_rdata_o == {2'h0, $past(tuning_value_o)}) else $error("tuning read wrong");
   a_reset_freq_default: assert property ($fell(reset_i) |-> postscale_sel_o == 2'h1)
      else $error("freq select not default");
   a_gain_decode: assert property (amp_gain_o != 2'h0 |-> use_external_o && !external_from_pin_o)
      else $error("gain outside resonator mode");
   a_pin_free: assert property (osc_pin_in_gpio_o |-> !use_external_o)
      else $error("pin freed in external mode");
   a_prog_locked: assert property (prog_rd_i && !prog_mode_i |=> prog_rdata_o == 16'h0000)
      else $error("word read outside programming");
   a_cfg_map: assert property (prog_rd_i && prog_mode_i && prog_addr_i != 14'h2007 &&
      prog_addr_i != 14'h2008 |=> prog_rdata_o == 16'h0000) else $error("unmapped word read");
   a_wake_hold: assert property (wake_i && !device_hold_reset_o && amp_gain_o != 2'h0 |=>
      device_hold_reset_o [*8]) else $error("wake did not hold");
endmodule // csm_clock_ctrl_props
bind csm_clock_ctrl csm_clock_ctrl_props csm_clock_ctrl_props_i (.clock_i, .reset_i, .wake_i,
   .reg_addr_i, .reg_rd_i, .reg_rdata_o, .prog_mode_i, .prog_addr_i, .prog_rd_i, .prog_rdata_o,
   .postscale_sel_o, .tuning_value_o, .osc_pin_in_gpio_o, .amp_gain_o, .use_external_o,
   .external_from_pin_o, .device_hold_reset_o);

//--- csm_clock_ctrl_test.sv
// csm_clock_ctrl_test.sv: self-checking bench of the clock mode block
// assumes the checker file is compiled alongside; 200 MHz clock
`timescale 1ns/100ps
module csm_clock_ctrl_test;
   logic clock_i = 1'b0, reset_i = 1'b1, cold_reset_i = 1'b1, wake_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, prog_mode_i = 1'b0, prog_wr_i = 1'b0;
   logic prog_rd_i = 1'b0, osc_locked_i = 1'b1, osc_stable_i = 1'b0, osc_pin_in_i = 1'b0;
   logic [13:0] prog_addr_i = 14'h0000;
   logic [15:0] prog_wdata_i = 16'h0000, prog_rdata_o, w;
   logic pin_ext = 1'b1, gpio_out_i = 1'b0, gpio_oe_n_i = 1'b1, last_pin = 1'b0;
   logic [1:0] postscale_sel_o, amp_gain_o, brownout_reset_select_o, g;
   logic [5:0] tuning_value_o;
   logic [2:0] c;
   logic [8:0] f;
   logic freq_multiplier_on_o, osc_pin_out_o, osc_pin_out_oe_n_o, gpio_in_o, osc_pin_in_gpio_o;
   logic use_external_o, external_from_pin_o, device_hold_reset_o, watchdog_on_o;
   logic powerup_timer_on_o, reset_pin_function_on_o, code_protect_bit_o;
   logic brownout_level_select_o, debug_on_o;
   wire logic osc_pin_out_i;
   int bad_count = 0, compares = 0, toggles = 0, t0;
   // the released pin floats high through the bench's stand-in pull-up
   assign osc_pin_out_i = osc_pin_out_oe_n_o ? pin_ext : osc_pin_out_o;
   always #2.5 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      if (osc_pin_out_o !== last_pin)
         toggles++;
      last_pin <= osc_pin_out_o;
   end
   csm_clock_ctrl csm_clock_ctrl_i (.clock_i, .reset_i, .cold_reset_i, .wake_i, .reg_addr_i,
      .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .prog_mode_i, .prog_addr_i,
      .prog_wdata_i, .prog_wr_i, .prog_rd_i, .prog_rdata_o, .osc_locked_i, .osc_stable_i,
      .intosc_clk_i(1'b0), .postscale_sel_o, .freq_multiplier_on_o, .tuning_value_o,
      .osc_pin_in_i, .osc_pin_out_i, .osc_pin_out_o, .osc_pin_out_oe_n_o, .gpio_out_i,
      .gpio_oe_n_i, .gpio_in_o, .osc_pin_in_gpio_o, .amp_gain_o, .use_external_o,
      .external_from_pin_o, .device_hold_reset_o, .watchdog_on_o, .powerup_timer_on_o,
      .reset_pin_function_on_o, .code_protect_bit_o, .brownout_reset_select_o,
      .brownout_level_select_o, .debug_on_o);
   task automatic close_out;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] gv, input logic [15:0] ev);
      compares++;
      if (gv !== ev) begin
         bad_count++;
         $display("wrong value at %0t got %h expected %h", $time, gv, ev);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask
   // the status register's hold flag follows start-up, so only mode and gain are compared
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 chk({8'h00, reg_rdata_o & ((a == 8'h02) ? 8'h1f : 8'hff)}, e);
   endtask
   task automatic pw(input logic [13:0] a, input logic [15:0] d);
      @(posedge clock_i);
      prog_addr_i <= a;
      prog_wdata_i <= d;
      prog_wr_i <= 1'b1;
      @(posedge clock_i);
      prog_wr_i <= 1'b0;
   endtask
   task automatic pr(input logic [13:0] a, input logic [15:0] e);
      @(posedge clock_i);
      prog_addr_i <= a;
      prog_rd_i <= 1'b1;
      @(posedge clock_i);
      prog_rd_i <= 1'b0;
      #1 chk(prog_rdata_o, e);
   endtask
   task automatic pump(input int n);
      repeat (2 * n) begin
         cycles(2);
         osc_pin_in_i <= ~osc_pin_in_i;
      end
   endtask
   task automatic do_reset(input logic cold);
      @(posedge clock_i);
      reset_i <= 1'b1;
      cold_reset_i <= cold;
      cycles(6);
      reset_i <= 1'b0;
      cold_reset_i <= 1'b0;
      cycles(1);
   endtask
   task automatic startup;
      int n;
      pump(1023);
      chk(device_hold_reset_o, 1'b1);
      pump(1);
      for (n = 0; n < 8 && device_hold_reset_o !== 1'b0; n++)
         @(posedge clock_i);
      chk(device_hold_reset_o, 1'b0);
      if (n == 8)
         close_out();
   endtask
   initial begin
      cycles(100000);
      bad_count++;
      close_out();
   end
   initial begin
      cycles(6);
      reset_i <= 1'b0;
      cold_reset_i <= 1'b0;
      cycles(1);
      chk(postscale_sel_o, 2'h1);
      rd(8'h00, 16'h0028);
      rd(8'h01, 16'h0000);
      wr(8'h05, 8'hff);
      rd(8'h05, 16'h0000);
      pr(14'h2007, 16'h0000);
      @(posedge clock_i) prog_mode_i <= 1'b1;
      pr(14'h2007, 16'hffff);
      pr(14'h2008, 16'hffff);
      pr(14'h2009, 16'h0000);
      wr(8'h00, 8'hff);
      rd(8'h00, 16'h0038);
      chk(postscale_sel_o, 2'h0);
      wr(8'h01, 8'hea);
      rd(8'h01, 16'h002a);
      chk(tuning_value_o, 6'h2a);
      @(posedge clock_i) osc_locked_i <= 1'b0;
      osc_stable_i <= 1'b1;
      do_reset(1'b0);
      rd(8'h00, 16'h0024);
      rd(8'h01, 16'h002a);
      // odd codes set every option field, even codes clear them
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         g = (c < 3'h3) ? c[1:0] + 2'h1 : 2'h0;
         w = 16'hc880 | {13'h0000, c} | (c[0] ? 16'h3778 : 16'h0000);
         pw(14'h2007, w);
         pr(14'h2007, w);
         cycles(3);
         chk(amp_gain_o, g);
         chk(use_external_o, c != 3'h4 && c != 3'h5);
         chk(external_from_pin_o, c == 3'h3 || c > 3'h5);
         chk(osc_pin_in_gpio_o, c == 3'h4 || c == 3'h5);
         rd(8'h02, {g, c});
         f = {freq_multiplier_on_o, watchdog_on_o, powerup_timer_on_o, reset_pin_function_on_o,
            code_protect_bit_o, brownout_reset_select_o, brownout_level_select_o, debug_on_o};
         chk(f, {9{c[0]}});
      end
      chk(osc_pin_out_oe_n_o, 1'b0);
      t0 = toggles;
      pump(16);
      cycles(4);
      chk(toggles - t0, 16'h0008);
      pw(14'h2007, 16'hc88e);
      gpio_out_i <= 1'b1;
      gpio_oe_n_i <= 1'b0;
      cycles(3);
      chk({osc_pin_out_oe_n_o, osc_pin_out_o}, 2'h1);
      t0 = toggles;
      pump(8);
      chk(toggles - t0, 16'h0000);
      gpio_oe_n_i <= 1'b1;
      pin_ext <= 1'b0;
      cycles(3);
      chk({osc_pin_out_oe_n_o, gpio_in_o}, 2'h2);
      pin_ext <= 1'b1;
      cycles(3);
      chk(gpio_in_o, 1'b1);
      pw(14'h2007, 16'hc888);
      do_reset(1'b0);
      startup();
      wake_i <= 1'b1;
      @(posedge clock_i) wake_i <= 1'b0;
      cycles(1);
      chk(device_hold_reset_o, 1'b1);
      startup();
      do_reset(1'b1);
      rd(8'h01, 16'h0000);
      pr(14'h2007, 16'hffff);
      close_out();
   end
endmodule // csm_clock_ctrl_test

//--- csm_clock_map.svh
// csm_clock_map.svh: offsets, field positions, reset values and counts of the clock mode block
// assumes inclusion by every design file that decodes registers
`ifndef CSM_CLOCK_MAP_SVH
`define CSM_CLOCK_MAP_SVH

// software register offsets on the plain register port
`define CSM_OFS_OSC_CONTROL 8'h00
`define CSM_OFS_OSC_TUNING 8'h01
`define CSM_OFS_MODE_STATUS 8'h02

// osc_control fields
`define CSM_FREQ_SEL_HI 5
`define CSM_FREQ_SEL_LO 4
`define CSM_LOCKED_BIT 3
`define CSM_STABLE_BIT 2
`define CSM_FREQ_SEL_RESET 2'h2

// osc_tuning fields
`define CSM_TUNE_HI 5
`define CSM_TUNE_RESET 6'h00

// configuration word addresses in program space
`define CSM_CFG1_ADDR 14'h2007
`define CSM_CFG2_ADDR 14'h2008
`define CSM_CFG_ERASED 16'hffff
`define CSM_CFG1_IMPL_MASK 16'h377f

// config_word_one fields
`define CSM_CFG_OSC_HI 2
`define CSM_CFG_OSC_LO 0
`define CSM_CFG_WDT_BIT 3
`define CSM_CFG_PWRT_BIT 4
`define CSM_CFG_RSTPIN_BIT 5
`define CSM_CFG_CP_BIT 6
`define CSM_CFG_BORSEL_HI 9
`define CSM_CFG_BORSEL_LO 8
`define CSM_CFG_BORLVL_BIT 10
`define CSM_CFG_MULT_BIT 12
`define CSM_CFG_DEBUG_BIT 13

// oscillator select codes
`define CSM_OSC_LP 3'h0
`define CSM_OSC_XT 3'h1
`define CSM_OSC_HS 3'h2
`define CSM_OSC_EC 3'h3
`define CSM_OSC_INTIO 3'h4
`define CSM_OSC_INTCLK 3'h5
`define CSM_OSC_RC_OSC_WITH_IO_PIN 3'h6
`define CSM_OSC_RC 3'h7

// resonator start-up count in oscillations
`define CSM_OST_COUNT 11'h400
`define CSM_CLKDIV_HALF 1'h1

`endif

//--- csm_config_store.sv
// csm_config_store.sv: the two configuration words, reached only by the programming port
// assumes a cold reset stands for an unprogrammed part, so words come up erased
`timescale 1ns/100ps
`include "csm_clock_map.svh"
module csm_config_store (
   input wire logic clock_i,
   input wire logic cold_reset_i,
   input wire logic prog_mode_i,
   input wire logic [13:0] prog_addr_i,
   input wire logic [15:0] prog_wdata_i,
   input wire logic prog_wr_i,
   input wire logic prog_rd_i,
   output logic [15:0] prog_rdata_o,
   output logic [15:0] cfg1_o
);
   logic [15:0] cfg1_q;
   logic [15:0] cfg2_q;
   logic [15:0] rdata_q;

   // unimplemented bits of word one always read as erased
   assign cfg1_o = cfg1_q | ~`CSM_CFG1_IMPL_MASK; // RULE10
   assign prog_rdata_o = rdata_q;

   always_ff @(posedge clock_i or posedge cold_reset_i) begin
      if (cold_reset_i) begin
         cfg1_q <= `CSM_CFG_ERASED;
         cfg2_q <= `CSM_CFG_ERASED;
      end else if (prog_mode_i && prog_wr_i) begin // RULE9
         if (prog_addr_i == `CSM_CFG1_ADDR) begin // RULE8
            cfg1_q <= prog_wdata_i & `CSM_CFG1_IMPL_MASK | ~`CSM_CFG1_IMPL_MASK;
         end
         if (prog_addr_i == `CSM_CFG2_ADDR) begin // RULE8
            cfg2_q <= prog_wdata_i;
         end
      end
   end

   always_ff @(posedge clock_i or posedge cold_reset_i) begin
      if (cold_reset_i) begin
         rdata_q <= 16'h0000;
      end else if (prog_mode_i && prog_rd_i) begin // RULE9
         if (prog_addr_i == `CSM_CFG1_ADDR) begin
            rdata_q <= cfg1_o;
         end else if (prog_addr_i == `CSM_CFG2_ADDR) begin
            rdata_q <= cfg2_q;
         end else begin
            rdata_q <= 16'h0000;
         end
      end else begin
         rdata_q <= 16'h0000;
      end
   end
endmodule // csm_config_store

//--- csm_divided_clock_output_div.sv
// csm_divided_clock_output_div.sv: divides a sampled oscillator level by four
// assumes the source level is synchronous to clock_i and far slower than it
`timescale 1ns/100ps
`include "csm_clock_map.svh"
module csm_divided_clock_output_div (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic enable_i,
   input wire logic src_i,
   output logic div_o
);
   logic src_q;
   logic half_q;
   logic div_q;
   logic rise;

   assign rise = src_i && !src_q;
   assign div_o = div_q;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         src_q <= 1'b0;
      end else begin
         src_q <= src_i;
      end
   end

   // two source rises per output half period gives divide by four
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         half_q <= 1'b0;
         div_q <= 1'b0;
      end else if (!enable_i) begin
         half_q <= 1'b0;
         div_q <= 1'b0;
      end else if (rise) begin
         half_q <= ~half_q;
         if (half_q == `CSM_CLKDIV_HALF) begin
            div_q <= ~div_q;
         end
      end
   end
endmodule // csm_divided_clock_output_div

//--- csm_pkg.sv
// csm_pkg.sv: types shared by the clock mode block
// assumes csm_clock_map.svh holds every number
package csm_pkg;
   typedef enum logic [2:0] {
      CSM_MODE_LOW_GAIN, CSM_MODE_MED_GAIN, CSM_MODE_HIGH_GAIN, CSM_MODE_EXT_CLOCK,
      CSM_MODE_INT_IO, CSM_MODE_INT_DIVIDED_CLOCK_OUTPUT, CSM_MODE_RC_IO, CSM_MODE_RC_DIVIDED_CLOCK_OUTPUT
   } csm_mode_e;
   typedef enum logic [1:0] {
      CSM_GAIN_OFF, CSM_GAIN_LOW, CSM_GAIN_MED, CSM_GAIN_HIGH
   } csm_gain_e;
   typedef enum logic [1:0] {
      CSM_OST_IDLE, CSM_OST_COUNT, CSM_OST_DONE
   } csm_ost_e;
endpackage
